// *** shared/rpt_map.vh ***
/*
  register offsets, field positions, reset values and timing figures of
  the rgb panel timing block. definitions only; included by rpt_top.v.
*/
`ifndef RPT_MAP_VH
`define RPT_MAP_VH

// register offsets on the 3-wire serial port (7-bit address)
`define RPT_OFS_CHIP_ID      7'h00
`define RPT_OFS_IF_CFG       7'h02
`define RPT_OFS_VSTART       7'h03
`define RPT_OFS_HSTART       7'h04
`define RPT_OFS_PSTART_LO    7'h05
`define RPT_OFS_PSTART_HI    7'h06
`define RPT_OFS_PEND_LO      7'h07
`define RPT_OFS_PEND_HI      7'h08
`define RPT_OFS_STATUS       7'h09
`define RPT_OFS_SOFT_RST     7'h0a
`define RPT_OFS_VCOM         7'h0b

// reset values
`define RPT_RST_IF_CFG       8'h00
`define RPT_RST_VSTART       8'h04
`define RPT_RST_HSTART       8'h1d
`define RPT_RST_PSTART_LO    8'h01
`define RPT_RST_PSTART_HI    8'h00
`define RPT_RST_PEND_LO      8'h20
`define RPT_RST_PEND_HI      8'h00
`define RPT_RST_SOFT_RST     8'h00
`define RPT_RST_VCOM         8'h67

// field positions in the interface configuration, soft reset and vcom registers
`define RPT_BIT_FRAMING      7
`define RPT_BIT_SYNC_POL     5
`define RPT_BIT_MAPPING      4
`define RPT_BIT_CLK_POL      3
`define RPT_BIT_SOFT_RST     0
`define RPT_VCOM_MSB         7
`define RPT_VCOM_LSB         5

// serial frame: rw bit, 7 address bits, 8 data bits
`define RPT_SER_HDR_BITS     5'd8
`define RPT_SER_FRAME_BITS   5'd16

// timing in pixel clock cycles and panel geometry
`define RPT_HSTART_MIN       6'd10
`define RPT_LINE_PIXELS      10'd240
`define RPT_GATE_HI_BASE     9'd256
`define RPT_GATE_LAST        9'd320
`define RPT_WHITE            18'h3ffff

`endif

// *** hw/rpt_fifo.v ***
/*
  two-entry buffer with valid/ready on both sides.
  assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module rpt_fifo #(
  parameter W = 27
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire         clr,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:1];
  reg         wr_ptr;
  reg         rd_ptr;
  reg [1:0]   count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else if (clr) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        count <= count + 2'd1;
      end else if (pop & ~push) begin
        count <= count - 2'd1;
      end
    end
  end
endmodule

// *** hw/rpt_top.v ***
/*
  rgb panel timing block: serial register file and the video input
  framing it controls (sync/de framing, polarity, pixel mapping, start
  delays, partial lines, software reset, 8-colour vcom amplitude).
  assumes every panel pin is asynchronous to core_clk and that core_clk
  runs well above twice the pixel clock and the serial clock.
*/
`timescale 1ns/10ps
`include "rpt_map.vh"
module rpt_top #(
  parameter [7:0] CHIP_ID = 8'h00  // arbitrary value
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // 3-wire serial port
  input  wire        cs_n,
  input  wire        scl,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  // rgb video pins
  input  wire        pclk,
  input  wire        vsync,
  input  wire        hsync,
  input  wire        de,
  input  wire [17:0] rgb,
  // pixel stream
  output wire        pix_valid,
  input  wire        pix_ready,
  output wire [17:0] pix_data,
  output wire [8:0]  pix_gate,
  // analog control
  output wire [2:0]  partial_vcom_amplitude
);
  // two-stage synchronisers for every pin
  reg  [24:0] pin_s1;
  reg  [24:0] pin_s2;
  wire [24:0] pin_raw = {cs_n, scl, sda_in, pclk, vsync, hsync, de, rgb};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 25'h1000000;
      pin_s2 <= 25'h1000000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire        cs_n_s  = pin_s2[24];
  wire        scl_s   = pin_s2[23];
  wire        sda_s   = pin_s2[22];
  wire        pclk_s  = pin_s2[21];
  wire        vs_s    = pin_s2[20];
  wire        hs_s    = pin_s2[19];
  wire        de_s    = pin_s2[18];
  wire [17:0] rgb_s   = pin_s2[17:0];

  // registers
  reg [7:0] if_cfg;
  reg [7:0] vstart;
  reg [7:0] hstart;
  reg [7:0] pstart_lo;
  reg [7:0] pstart_hi;
  reg [7:0] pend_lo;
  reg [7:0] pend_hi;
  reg [7:0] soft_rst;
  reg [7:0] vcom;
  reg       sw_rst;
  reg       overrun;
  reg       in_frame;

  // serial receiver
  reg       scl_d;
  reg [4:0] bit_cnt;
  reg [6:0] shift;
  reg       rd_mode;
  reg [7:0] rd_shift;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire hdr_done = scl_rise & (bit_cnt == `RPT_SER_HDR_BITS - 5'd1);
  wire frm_done = scl_rise & (bit_cnt == `RPT_SER_FRAME_BITS - 5'd1);
  // header completes on the 8th edge: rw is shift[6], address the rest
  wire       rd_req  = hdr_done & shift[6];
  wire [6:0] rd_addr = {shift[5:0], sda_s};
  // frame completes on the 16th edge: data high seven bits are in shift, lsb on sda_s
  wire       wr_en   = frm_done & ~rd_mode & ~cs_n_s;
  wire [7:0] wr_data = {shift[6:0], sda_s};
  reg  [6:0] wr_addr;
  reg  [7:0] rd_val;

  always @* begin
    case (rd_addr)
      `RPT_OFS_CHIP_ID:   rd_val = CHIP_ID;
      `RPT_OFS_IF_CFG:    rd_val = if_cfg;
      `RPT_OFS_VSTART:    rd_val = vstart;
      `RPT_OFS_HSTART:    rd_val = hstart;
      `RPT_OFS_PSTART_LO: rd_val = pstart_lo;
      `RPT_OFS_PSTART_HI: rd_val = pstart_hi;
      `RPT_OFS_PEND_LO:   rd_val = pend_lo;
      `RPT_OFS_PEND_HI:   rd_val = pend_hi;
      `RPT_OFS_STATUS:    rd_val = {6'h00, in_frame, overrun};
      `RPT_OFS_SOFT_RST:  rd_val = soft_rst;
      `RPT_OFS_VCOM:      rd_val = vcom;
      default:            rd_val = 8'h00;
    endcase
  end

  // chip select high drops any partial word so the host can resend it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d    <= 1'b0;
      bit_cnt  <= 5'd0;
      shift    <= 7'h00;
      wr_addr  <= 7'h00;
      rd_mode  <= 1'b0;
      rd_shift <= 8'h00;
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
    end else begin
      scl_d <= scl_s;
      if (cs_n_s) begin
        bit_cnt <= 5'd0;
        rd_mode <= 1'b0;
        sda_oe  <= 1'b0;
      end else begin
        if (scl_rise && bit_cnt != `RPT_SER_FRAME_BITS) begin
          shift   <= {shift[5:0], sda_s};
          bit_cnt <= bit_cnt + 5'd1;
        end
        if (hdr_done) begin
          wr_addr <= rd_addr;
        end
        if (rd_req) begin
          rd_mode  <= 1'b1;
          rd_shift <= rd_val;
        end
        // read data leaves on falling edges so the host samples on rising
        if (scl_fall && rd_mode) begin
          if (bit_cnt == `RPT_SER_FRAME_BITS) begin
            sda_oe <= 1'b0;
          end else begin
            sda_oe   <= 1'b1;
            sda_out  <= rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b0};
          end
        end
      end
    end
  end

  // register file; soft reset restores defaults one cycle after the write
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_rst <= 1'b0;
    end else begin
      sw_rst <= wr_en & (wr_addr == `RPT_OFS_SOFT_RST) &
                wr_data[`RPT_BIT_SOFT_RST];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      if_cfg    <= `RPT_RST_IF_CFG;
      vstart    <= `RPT_RST_VSTART;
      hstart    <= `RPT_RST_HSTART;
      pstart_lo <= `RPT_RST_PSTART_LO;
      pstart_hi <= `RPT_RST_PSTART_HI;
      pend_lo   <= `RPT_RST_PEND_LO;
      pend_hi   <= `RPT_RST_PEND_HI;
      soft_rst  <= `RPT_RST_SOFT_RST;
      vcom      <= `RPT_RST_VCOM;
    end else if (sw_rst) begin
      if_cfg    <= `RPT_RST_IF_CFG;
      vstart    <= `RPT_RST_VSTART;
      hstart    <= `RPT_RST_HSTART;
      pstart_lo <= `RPT_RST_PSTART_LO;
      pstart_hi <= `RPT_RST_PSTART_HI;
      pend_lo   <= `RPT_RST_PEND_LO;
      pend_hi   <= `RPT_RST_PEND_HI;
      soft_rst  <= `RPT_RST_SOFT_RST;
      vcom      <= `RPT_RST_VCOM;
    end else if (wr_en) begin
      case (wr_addr)
        `RPT_OFS_IF_CFG:    if_cfg    <= wr_data;
        `RPT_OFS_VSTART:    vstart    <= {4'h0, wr_data[3:0]};
        `RPT_OFS_HSTART:    hstart    <= {2'h0, wr_data[5:0]};
        `RPT_OFS_PSTART_LO: pstart_lo <= wr_data;
        `RPT_OFS_PSTART_HI: pstart_hi <= {7'h00, wr_data[0]};
        `RPT_OFS_PEND_LO:   pend_lo   <= wr_data;
        `RPT_OFS_PEND_HI:   pend_hi   <= {7'h00, wr_data[0]};
        `RPT_OFS_SOFT_RST:  soft_rst  <= wr_data;
        `RPT_OFS_VCOM:      vcom      <= wr_data;
        default:            soft_rst  <= soft_rst;
      endcase
    end
  end

  // vcom offset code: 000 is -0.3V, each step +0.1V, 111 is +0.4V
  assign partial_vcom_amplitude = vcom[`RPT_VCOM_MSB:`RPT_VCOM_LSB];

  // pin polarity; a polarity change glitches edges, so set it between frames
  wire sync_pol = if_cfg[`RPT_BIT_SYNC_POL];
  wire vs_act   = vs_s ^ ~sync_pol;
  wire hs_act   = hs_s ^ ~sync_pol;
  reg  vs_d;
  reg  hs_d;
  reg  pclk_d;
  wire vs_start = vs_act & ~vs_d;
  wire hs_start = hs_act & ~hs_d;
  wire pix_edge = if_cfg[`RPT_BIT_CLK_POL] ? (~pclk_s & pclk_d)
                                           : (pclk_s & ~pclk_d);

  // frame-stable copies, loaded only at vsync
  reg       sh_framing;
  reg       sh_mapping;
  reg [3:0] sh_vstart;
  reg [5:0] sh_hstart;
  reg [8:0] sh_pstart;
  reg [8:0] sh_pend;
  reg [8:0] line_cnt;
  reg [9:0] px_cnt;

  // gate number from split code: high bit adds 256
  wire [8:0] pstart_gate = pstart_hi[0] ? `RPT_GATE_HI_BASE + {1'b0, pstart_lo}
                                        : {1'b0, pstart_lo};
  wire [8:0] pend_gate   = pend_hi[0] ? `RPT_GATE_HI_BASE + {1'b0, pend_lo}
                                      : {1'b0, pend_lo};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vs_d       <= 1'b1;  // no false sync edge right after reset
      hs_d       <= 1'b1;
      pclk_d     <= 1'b0;
      in_frame   <= 1'b0;
      sh_framing <= 1'b0;
      sh_mapping <= 1'b0;
      sh_vstart  <= 4'h4;
      sh_hstart  <= 6'h1d;
      sh_pstart  <= 9'h001;
      sh_pend    <= 9'h020;
      line_cnt   <= 9'h000;
      px_cnt     <= 10'h000;
    end else begin
      vs_d   <= vs_act;
      hs_d   <= hs_act;
      pclk_d <= pclk_s;
      if (sw_rst) begin
        in_frame <= 1'b0;
      end else if (vs_start) begin
        in_frame   <= 1'b1;
        sh_framing <= if_cfg[`RPT_BIT_FRAMING];
        sh_mapping <= if_cfg[`RPT_BIT_MAPPING];
        sh_vstart  <= vstart[3:0];
        sh_hstart  <= hstart[5:0];
        sh_pstart  <= pstart_gate;
        sh_pend    <= pend_gate;
        line_cnt   <= 9'h000;
      end else if (hs_start && line_cnt != 9'h1ff) begin
        line_cnt <= line_cnt + 9'h001;
      end
      if (hs_start) begin
        px_cnt <= 10'h000;
      end else if (pix_edge && px_cnt != 10'h3ff) begin
        px_cnt <= px_cnt + 10'h001;
      end
    end
  end

  // line n counted from vsync is the first valid one when n equals the code
  wire [8:0] gate     = line_cnt - {5'h00, sh_vstart} + 9'h001;
  wire       line_ok  = (line_cnt >= {5'h00, sh_vstart}) &&
                        (gate <= `RPT_GATE_LAST);
  wire [5:0] h_delay  = (sh_hstart < `RPT_HSTART_MIN) ? `RPT_HSTART_MIN
                                                      : sh_hstart;
  wire       col_ok   = (px_cnt >= {4'h0, h_delay}) &&
                        (px_cnt < {4'h0, h_delay} + `RPT_LINE_PIXELS);

  // white fill: de low in de framing, outside partial window otherwise
  wire       outside  = (gate < sh_pstart) || (gate > sh_pend);
  wire       white    = sh_framing ? outside : ~de_s;

  // 5:6:5 widened to 6:6:6 by repeating each short field's msb
  wire [17:0] mapped  = sh_mapping ?
                        {rgb_s[15:11], rgb_s[15], rgb_s[10:5],
                         rgb_s[4:0], rgb_s[4]} : rgb_s;
  wire [17:0] pixel   = white ? `RPT_WHITE : mapped;

  // the host clock cannot be stalled; a full buffer drops and flags
  wire        take    = in_frame & pix_edge & line_ok & col_ok;
  wire        buf_rdy;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (sw_rst) begin
      overrun <= 1'b0;
    end else if (take && !buf_rdy) begin
      overrun <= 1'b1;
    end
  end

  rpt_fifo #(
    .W (27)
  ) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clr       (sw_rst),
    .in_valid  (take),
    .in_ready  (buf_rdy),
    .in_data   ({gate, pixel}),
    .out_valid (pix_valid),
    .out_ready (pix_ready),
    .out_data  ({pix_gate, pix_data})
  );
endmodule

// *** test/rpt_host_video.sv ***
/* host video source for rpt_top: one frame of LINES lines per go pulse.
   assumes the bench holds sync_pos and clk_inv steady during a frame. */
`timescale 1ns/10ps
module rpt_host_video #(
  parameter LINES = 3,
  parameter EDGES = 254,
  parameter HALF  = 4
) (
  // control
  input  wire        core_clk,
  input  wire        go,
  input  wire        sync_pos,
  input  wire        clk_inv,
  input  wire [1:0]  de_low,
  output reg         busy,
  // rgb pins
  output reg         pclk,
  output reg         vsync,
  output reg         hsync,
  output reg         de,
  output reg  [17:0] rgb
);
  integer l, e;
  initial begin
    busy = 0; pclk = 0; vsync = 1; hsync = 1; de = 0; rgb = 0;
  end
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // pclk stands still outside lines, idle levels settle before vsync
  always @(posedge core_clk) begin
    if (go) begin
      busy  <= 1;
      pclk  <= clk_inv;
      vsync <= !sync_pos;
      hsync <= !sync_pos;
      tick(8);
      vsync <= sync_pos;
      tick(8);
      vsync <= !sync_pos;
      for (l = 1; l <= LINES; l = l + 1) begin
        tick(8);
        hsync <= sync_pos;
        tick(8);
        hsync <= !sync_pos;
        de    <= (l != de_low);
        for (e = 0; e < EDGES; e = e + 1) begin
          rgb  <= {l[8:0], e[8:0]};
          tick(HALF);
          pclk <= !clk_inv;
          tick(HALF);
          pclk <= clk_inv;
        end
        de  <= 0;
        rgb <= ~rgb;
      end
      tick(8);
      busy <= 0;
    end
  end
endmodule

// *** test/rpt_top_asserts.sv ***
/* checker for rpt_top: serial output timing and pixel stream behaviour.
   assumes it is bound to rpt_top and sees only its ports. */
`timescale 1ns/10ps
module rpt_chk (
  // clock and reset
  input wire        core_clk,
  input wire        rst_n,
  // serial port
  input wire        cs_n,
  input wire        scl,
  input wire        sda_out,
  input wire        sda_oe,
  // video side
  input wire        pclk,
  input wire        pix_valid,
  input wire        pix_ready,
  input wire [17:0] pix_data,
  input wire [8:0]  pix_gate,
  input wire [2:0]  partial_vcom_amplitude
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_vcom_reset:
    assert property ($rose(rst_n) |-> partial_vcom_amplitude == 3'b011)
    else $error("vcom not at reset code");
  chk_oe_idle:
    assert property (cs_n [*5] |-> !sda_oe)
    else $error("sda driven without chip select");
  chk_oe_rise:
    assert property ($rose(sda_oe) |-> !scl && !cs_n)
    else $error("sda drive began off a falling scl");
  chk_shift_fall:
    assert property (sda_oe && $past(sda_oe) && $changed(sda_out) |-> !scl)
    else $error("sda changed while scl high");
  chk_word_hold:
    assert property (pix_valid && !pix_ready && cs_n |=>
      pix_valid && $stable(pix_data) && $stable(pix_gate))
    else $error("pixel word lost while stalled");
  chk_gate_range:
    assert property (pix_valid |-> pix_gate >= 9'd1 && pix_gate <= 9'd320)
    else $error("gate number out of range");
  chk_quiet_pclk:
    assert property ((!pix_valid && $stable(pclk)) [*6] |=> !pix_valid)
    else $error("pixel without a pixel clock edge");
  chk_vcom_hold:
    assert property (cs_n [*8] |-> $stable(partial_vcom_amplitude))
    else $error("vcom changed without a write");
endmodule

bind rpt_top rpt_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .scl(scl),
  .sda_out(sda_out), .sda_oe(sda_oe), .pclk(pclk), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .pix_data(pix_data), .pix_gate(pix_gate),
  .partial_vcom_amplitude(partial_vcom_amplitude));

// *** test/rpt_top_bench.sv ***
/* rpt_top bench: register access over the serial port and three frames.
   assumes rpt_top, rpt_host_video and rpt_chk are compiled first. */
`timescale 1ns/10ps
`define CHK(a, b) begin \
  check_count = check_count + 1; \
  if ((a) !== (b)) begin \
    miscompares = miscompares + 1; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); \
  end end
module rpt_top_bench;
  localparam        HS = 20;
  localparam [71:0] RA = 72'h02_03_04_05_06_07_08_0a_0b;
  localparam [71:0] RV = 72'h00_04_1d_01_00_20_00_00_67;
  reg         core_clk, rst_n, cs_n, scl, hsda, host_oe;
  reg         pix_ready, go, spos, cinv, de_mode, m16;
  reg  [1:0]  de_low;
  reg  [7:0]  r;
  reg  [17:0] src, ex;
  wire        sda_out, sda_oe, pclk, vsync, hsync, de, pix_valid, busy;
  wire [17:0] rgb, pix_data;
  wire [8:0]  pix_gate;
  wire [2:0]  vcom;
  // a released sda line shows the inverse of the last host bit
  wire        sda_line = sda_oe ? sda_out : (host_oe ? hsda : ~hsda);
  integer     miscompares, check_count, nw, vst, hs, win_end, g, k;

  rpt_top dut (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .pclk(pclk),
    .vsync(vsync), .hsync(hsync), .de(de), .rgb(rgb), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data), .pix_gate(pix_gate),
    .partial_vcom_amplitude(vcom));
  rpt_host_video host (
    .core_clk(core_clk), .go(go), .sync_pos(spos), .clk_inv(cinv),
    .de_low(de_low), .busy(busy), .pclk(pclk), .vsync(vsync), .hsync(hsync),
    .de(de), .rgb(rgb));

  always #2 core_clk = ~core_clk;

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task ser(input rw, input [6:0] a, input [7:0] d);
    integer i;
    reg [15:0] w;
    begin
      w = {rw, a, d};
      @(posedge core_clk);
      cs_n <= 0;
      for (i = 15; i >= 0; i = i - 1) begin
        hsda    <= w[i];
        host_oe <= !(rw && i < 8);
        repeat (HS) @(posedge core_clk);
        scl <= 1;
        if (i < 8) r[i] = sda_line;
        repeat (HS) @(posedge core_clk);
        scl <= 0;
      end
      repeat (HS) @(posedge core_clk);
      cs_n    <= 1;
      host_oe <= 1;
      repeat (260) @(posedge core_clk);
    end
  endtask
  task rdc(input [6:0] a, input [7:0] e);
    begin
      ser(1'b1, a, 8'h00);
      `CHK(r, e)
    end
  endtask
  task frame(input integer words);
    begin
      nw = 0;
      go <= 1;
      @(posedge core_clk);
      go <= 0;
      repeat (2) @(posedge core_clk);
      for (k = 0; k < 20000 && busy; k = k + 1) @(posedge core_clk);
      if (busy) begin
        miscompares = miscompares + 1;
        stop_test;
      end
      repeat (8) @(posedge core_clk);
      if (words > 0) `CHK(nw, words)
    end
  endtask

  // every taken word is checked against the source pattern of the host
  always @(posedge core_clk) begin
    if (rst_n && pix_valid === 1'b1 && pix_ready) begin
      g   = nw / 240 + 1;
      src = {9'(g + vst - 1), 9'(hs + nw % 240)};
      ex  = m16 ? {src[15:11], src[15], src[10:5], src[4:0], src[4]} : src;
      if (de_mode ? (g + vst - 1 == de_low) : (g > win_end)) ex = 18'h3ffff;
      `CHK(pix_data, ex)
      `CHK(pix_gate, 9'(g))
      nw = nw + 1;
    end
  end

  initial begin
    rst_n = 0; cs_n = 1; scl = 0; hsda = 0; host_oe = 1; pix_ready = 1;
    go = 0; spos = 0; cinv = 0; de_low = 2; de_mode = 1; m16 = 0;
    core_clk = 0; miscompares = 0; check_count = 0; nw = 0;
    vst = 1; hs = 10; win_end = 320; r = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    repeat (4) @(posedge core_clk);
    `CHK(vcom, 3'b011)
    for (k = 0; k < 9; k = k + 1) rdc(RA[8*k+:7], RV[8*k+:8]);
    rdc(7'h20, 8'h00);
    // chip id parameter left at its default
    rdc(7'h00, 8'h00);
    ser(1'b0, 7'h0b, 8'he0);
    `CHK(vcom, 3'b111)
    $display("test registers done");
    ser(1'b0, 7'h03, 8'h01);
    ser(1'b0, 7'h04, 8'h05);
    frame(720);
    $display("test de framing done");
    spos <= 1;
    cinv <= 1;
    ser(1'b0, 7'h03, 8'h02);
    ser(1'b0, 7'h04, 8'h0c);
    ser(1'b0, 7'h07, 8'h01);
    ser(1'b0, 7'h02, 8'hb8);
    de_mode = 0; m16 = 1; vst = 2; hs = 12; win_end = 1;
    frame(480);
    $display("test sync framing done");
    pix_ready <= 0;
    frame(0);
    // status: overrun and in-frame both set after a stalled frame
    rdc(7'h09, 8'h03);
    `CHK(r[0], 1'b1)
    ser(1'b0, 7'h0a, 8'h01);
    `CHK(pix_valid, 1'b0)
    `CHK(vcom, 3'b011)
    for (k = 0; k < 9; k = k + 1) rdc(RA[8*k+:7], RV[8*k+:8]);
    // host idle sync level is active under the reset polarity: in-frame
    rdc(7'h09, 8'h02);
    `CHK(r[0], 1'b0)
    pix_ready <= 1;
    $display("test overrun and soft reset done");
    stop_test;
  end
endmodule
